// [tmrwg_pkg.sv]
// package for the 8-bit timer waveform generator: register map, field layout, resets
// assumes a single 250 MHz clock and a simple strobe-based register port
package tmrwg_pkg;
	localparam int CLK_PERIOD_NS = 4;
	// register offsets (byte addresses on the register port)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_COUNT = 4'h1;
	localparam logic [3:0] ADDR_CMPV = 4'h2;
	localparam logic [3:0] ADDR_FLAGS = 4'h3;
	localparam logic [3:0] ADDR_PIN = 4'h4;
	// control register fields
	localparam int CTRL_FORCE_BIT = 7;
	localparam int CTRL_WAVE_LO = 6;
	localparam int CTRL_COM_HI = 5;
	localparam int CTRL_COM_LO = 4;
	localparam int CTRL_WAVE_HI = 3;
	localparam int CTRL_CS_HI = 2;
	localparam int CTRL_CS_LO = 0;
	// flags register fields
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_BIT = 1;
	// pin register fields
	localparam int PIN_DIR_BIT = 0;
	localparam int PIN_PORT_BIT = 1;
	localparam int PIN_STATE_BIT = 2;
	// reset values and counter landmarks
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] CMPV_RESET = 8'h00;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [9:0] PRESCALE_RESET = 10'h000;
	// waveform mode encodings
	localparam logic [1:0] WAVE_NORMAL = 2'h0;
	localparam logic [1:0] WAVE_FAST_PWM = 2'h1;
	localparam logic [1:0] WAVE_CLEAR_ON_MATCH = 2'h2;
	localparam logic [1:0] WAVE_UNUSED = 2'h3;
	// compare output mode encodings
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	// clock select encodings: prescale factors 1, 8, 32, 64, 128, 256, 1024
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV32 = 3'h3;
	localparam logic [2:0] CS_DIV64 = 3'h4;
	localparam logic [2:0] CS_DIV128 = 3'h5;
	localparam logic [2:0] CS_DIV256 = 3'h6;
	localparam logic [2:0] CS_DIV1024 = 3'h7;
endpackage : tmrwg_pkg

// [tmrwg_timer.sv]
// 8-bit timer with compare output unit: normal, clear-on-match and fast pwm modes
// assumes one clock; registers reached over a strobe port; read data one cycle later
`timescale 1ns/10ps
// Function
// RULE1: nonzero compare output mode makes compare state replace port value.
// RULE2: pin driver enabled only by pin direction bit.
// RULE3: override depends only on compare output mode, not waveform mode.
// RULE4: compare state can be initialised before pin becomes output.
// RULE5: compare output mode zero leaves compare state unchanged at match.
// RULE6: new output mode acts at next match; force applies immediately in non-pwm.
// RULE7: output mode never alters counting; waveform mode alone does.
// RULE8: normal mode counts up always, wrapping 0xff to 0x00.
// RULE9: normal mode sets overflow flag as counter becomes zero.
// RULE10: software may write counter value any time in normal mode.
// RULE11: clear-on-match mode clears counter when it equals compare value.
// RULE12: clear-on-match uses compare value unbuffered; missed match wraps via 0xff.
// RULE13: clear-on-match with mode one toggles output on each match.
// RULE14: clear-on-match sets overflow flag when counter rolls max to 0x00.
// RULE15: timer clock from io clock divided by 1,8,32,64,128,256,1024.
// RULE16: fast pwm counts up to max, clears the following timer cycle.
// RULE17: fast pwm mode two clears on match, sets at bottom; three inverts.
// RULE18: fast pwm sets overflow flag each time counter reaches max.
// RULE19: fast pwm period is 256 timer clocks.
// RULE20: fast pwm compare zero spikes; compare max gives constant level.
// RULE21: fast pwm mode one toggles on match, compare stays double buffered.
// RULE22: pwm compare value double buffered; other modes write it directly.
// RULE23: force updates compare state only, no flag, no counter change.
// RULE24: bottom is 0x00 and maximum is 0xff.
// RULE25: equality sets compare match flag at next timer clock.
module tmrwg_timer #(
	parameter int WIDTH = 8
) (
	clk,
	srst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	port_value,
	pin_out,
	pin_oe,
	overflow_flag,
	compare_match_flag
);
	input wire logic clk;
	input wire logic srst;
	input wire logic [3:0] reg_addr;
	input wire logic [7:0] reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output logic [7:0] reg_rdata;
	input wire logic port_value;
	output logic pin_out;
	output logic pin_oe;
	output logic overflow_flag;
	output logic compare_match_flag;

	logic [1:0] waveform_mode_field_q;
	logic [1:0] compare_output_mode_field_q;
	logic [2:0] clock_select_q;
	logic [7:0] counter_value_q;
	logic [7:0] compare_value_q;
	logic [7:0] compare_buffer_q;
	logic compare_output_state_q;
	logic overflow_flag_q;
	logic compare_match_flag_q;
	logic pin_direction_bit_q;
	logic [9:0] prescale_q;
	logic match_pending_q;
	logic block_match_q;
	logic [7:0] rdata_q;

	logic wr_ctrl;
	logic wr_count;
	logic wr_cmpv;
	logic wr_flags;
	logic wr_pin;
	logic tick;
	logic is_pwm;
	logic force_strobe;
	logic at_top;
	logic match;
	logic [7:0] count_next;

	logic pwm_top;

	// prescaler tap for each clock select; stop and unknown codes never tick
	function automatic logic prescale_tick(input logic [2:0] cs, input logic [9:0] pre);
		logic hit;
		hit = 1'b0;
		case (cs)
			tmrwg_pkg::CS_STOP: hit = 1'b0;
			tmrwg_pkg::CS_DIV1: hit = 1'b1;
			tmrwg_pkg::CS_DIV8: hit = (pre[2:0] == 3'h7);
			tmrwg_pkg::CS_DIV32: hit = (pre[4:0] == 5'h1f);
			tmrwg_pkg::CS_DIV64: hit = (pre[5:0] == 6'h3f);
			tmrwg_pkg::CS_DIV128: hit = (pre[6:0] == 7'h7f);
			tmrwg_pkg::CS_DIV256: hit = (pre[7:0] == 8'hff);
			tmrwg_pkg::CS_DIV1024: hit = (pre == 10'h3ff);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : prescale_tick

	// next compare state at a match or a force; shared so both act alike
	function automatic logic match_action(input logic [1:0] com, input logic cur);
		logic nxt;
		nxt = cur;
		case (com)
			tmrwg_pkg::COM_TOGGLE: nxt = !cur;
			tmrwg_pkg::COM_CLEAR: nxt = 1'b0;
			tmrwg_pkg::COM_SET: nxt = 1'b1;
			default: nxt = cur;
		endcase
		return nxt;
	endfunction : match_action

	// next compare state at the max to bottom step of fast pwm
	// in modes two and three the bottom action beats a match at max, so a compare at max gives a steady level
	function automatic logic top_action(input logic [1:0] com, input logic cur,
		input logic hit);
		logic nxt;
		nxt = cur;
		case (com)
			tmrwg_pkg::COM_TOGGLE: nxt = hit ? !cur : cur;
			tmrwg_pkg::COM_CLEAR: nxt = 1'b1;
			tmrwg_pkg::COM_SET: nxt = 1'b0;
			default: nxt = cur;
		endcase
		return nxt;
	endfunction : top_action

	// control register image for readback; the force bit always reads zero
	function automatic logic [7:0] ctrl_image(input logic [1:0] wave, input logic [1:0] com,
		input logic [2:0] cs);
		logic [7:0] img;
		img = 8'h00;
		img[tmrwg_pkg::CTRL_WAVE_LO] = wave[0];
		img[tmrwg_pkg::CTRL_WAVE_HI] = wave[1];
		img[tmrwg_pkg::CTRL_COM_HI:tmrwg_pkg::CTRL_COM_LO] = com;
		img[tmrwg_pkg::CTRL_CS_HI:tmrwg_pkg::CTRL_CS_LO] = cs;
		return img;
	endfunction : ctrl_image

	assign wr_ctrl = reg_wr && (reg_addr == tmrwg_pkg::ADDR_CTRL);
	assign wr_count = reg_wr && (reg_addr == tmrwg_pkg::ADDR_COUNT);
	assign wr_cmpv = reg_wr && (reg_addr == tmrwg_pkg::ADDR_CMPV);
	assign wr_flags = reg_wr && (reg_addr == tmrwg_pkg::ADDR_FLAGS);
	assign wr_pin = reg_wr && (reg_addr == tmrwg_pkg::ADDR_PIN);
	assign is_pwm = (waveform_mode_field_q == tmrwg_pkg::WAVE_FAST_PWM);

	// RULE15 prescaled timer clock enable
	always_comb begin
		tick = prescale_tick(clock_select_q, prescale_q);
	end

	always_ff @(posedge clk) begin
		if (srst || clock_select_q == tmrwg_pkg::CS_STOP) begin
			prescale_q <= tmrwg_pkg::PRESCALE_RESET;
		end else begin
			prescale_q <= prescale_q + 10'h001;
		end
	end

	// RULE23 force acts only outside pwm
	assign force_strobe = wr_ctrl && reg_wdata[tmrwg_pkg::CTRL_FORCE_BIT] && !is_pwm;
	// RULE24 fixed bottom and max
	// RULE11 top is compare value in clear-on-match
	assign at_top = (waveform_mode_field_q == tmrwg_pkg::WAVE_CLEAR_ON_MATCH) ?
		(counter_value_q == compare_value_q) : (counter_value_q == tmrwg_pkg::COUNT_MAX);
	assign match = (counter_value_q == compare_value_q) && !block_match_q;
	// fast pwm step from max to bottom, the moment the output is set or cleared
	assign pwm_top = is_pwm && at_top;

	// RULE7 counting uses waveform mode only
	always_comb begin
		case (waveform_mode_field_q)
			// RULE11 clear at compare value, unbuffered
			// RULE12 missed match runs through max
			tmrwg_pkg::WAVE_CLEAR_ON_MATCH: begin
				count_next = (counter_value_q == compare_value_q) ? tmrwg_pkg::COUNT_BOTTOM :
					counter_value_q + 8'h01;
			end
			// RULE8 free-running wrap
			// RULE16 up to max then clear
			// RULE19 256-step period
			default: count_next = counter_value_q + 8'h01;
		endcase
	end

	// RULE10 software write wins over counting
	always_ff @(posedge clk) begin
		if (srst) begin
			counter_value_q <= tmrwg_pkg::COUNT_RESET;
		end else if (wr_count) begin
			counter_value_q <= reg_wdata;
		end else if (tick) begin
			counter_value_q <= count_next;
		end
	end

	// a counter write masks the match in the following timer cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			block_match_q <= 1'b0;
		end else if (wr_count) begin
			block_match_q <= 1'b1;
		end else if (tick) begin
			block_match_q <= 1'b0;
		end
	end

	// RULE22 double buffer in pwm, direct otherwise
	always_ff @(posedge clk) begin
		if (srst) begin
			compare_buffer_q <= tmrwg_pkg::CMPV_RESET;
		end else if (wr_cmpv) begin
			compare_buffer_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			compare_value_q <= tmrwg_pkg::CMPV_RESET;
		end else if (wr_cmpv && !is_pwm) begin
			compare_value_q <= reg_wdata;
		end else if (tick && pwm_top) begin
			// RULE21 buffered update at top
			compare_value_q <= compare_buffer_q;
		end else if (!is_pwm && !wr_cmpv) begin
			compare_value_q <= compare_buffer_q;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			waveform_mode_field_q <= tmrwg_pkg::WAVE_NORMAL;
			compare_output_mode_field_q <= tmrwg_pkg::COM_OFF;
			clock_select_q <= tmrwg_pkg::CS_STOP;
		end else if (wr_ctrl) begin
			waveform_mode_field_q <= {reg_wdata[tmrwg_pkg::CTRL_WAVE_HI],
				reg_wdata[tmrwg_pkg::CTRL_WAVE_LO]};
			// RULE6 takes effect from next match
			compare_output_mode_field_q <= reg_wdata[tmrwg_pkg::CTRL_COM_HI:tmrwg_pkg::CTRL_COM_LO];
			clock_select_q <= reg_wdata[tmrwg_pkg::CTRL_CS_HI:tmrwg_pkg::CTRL_CS_LO];
		end
	end

	// RULE25 match seen on a timer tick flags next cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			match_pending_q <= 1'b0;
		end else if (tick) begin
			match_pending_q <= match;
		end
	end

	// set wins over software clear (write one to clear)
	always_ff @(posedge clk) begin
		if (srst) begin
			compare_match_flag_q <= 1'b0;
		end else if (tick && match_pending_q) begin
			compare_match_flag_q <= 1'b1;
		end else if (wr_flags && reg_wdata[tmrwg_pkg::FLAG_CMP_BIT]) begin
			compare_match_flag_q <= 1'b0;
		end
	end

	// RULE9 set as count becomes zero
	// RULE14 set on max to zero roll
	// RULE18 set on reaching max
	always_ff @(posedge clk) begin
		if (srst) begin
			overflow_flag_q <= 1'b0;
		end else if (tick && counter_value_q == tmrwg_pkg::COUNT_MAX && !wr_count) begin
			overflow_flag_q <= 1'b1;
		end else if (wr_flags && reg_wdata[tmrwg_pkg::FLAG_OVF_BIT]) begin
			overflow_flag_q <= 1'b0;
		end
	end

	// RULE5 mode zero holds state
	// RULE13 toggle in clear-on-match
	// RULE17 pwm clear or set at match, opposite at bottom
	// RULE20 bottom action first so compare zero leaves a spike
	// RULE4 force sets initial state before output enable
	always_ff @(posedge clk) begin
		if (srst) begin
			compare_output_state_q <= 1'b0;
		end else if (force_strobe) begin
			// the written mode bits decide what the force does
			compare_output_state_q <= match_action(
				reg_wdata[tmrwg_pkg::CTRL_COM_HI:tmrwg_pkg::CTRL_COM_LO],
				compare_output_state_q);
		end else if (tick && pwm_top) begin
			compare_output_state_q <= top_action(compare_output_mode_field_q,
				compare_output_state_q, match);
		end else if (tick && match) begin
			compare_output_state_q <= match_action(compare_output_mode_field_q,
				compare_output_state_q);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_direction_bit_q <= 1'b0;
		end else if (wr_pin) begin
			pin_direction_bit_q <= reg_wdata[tmrwg_pkg::PIN_DIR_BIT];
		end
	end

	// RULE1 override when mode nonzero
	// RULE3 independent of waveform mode
	// RULE2 direction bit gates driver
	// the compare state is kept even while the port value drives the pin
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_out <= 1'b0;
		end else begin
			pin_out <= (compare_output_mode_field_q != tmrwg_pkg::COM_OFF) ?
				compare_output_state_q : port_value;
		end
	end

	// driver follows the direction bit alone, whatever the mode fields say
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_oe <= 1'b0;
		end else begin
			pin_oe <= pin_direction_bit_q;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				tmrwg_pkg::ADDR_CTRL: rdata_q <= ctrl_image(waveform_mode_field_q,
					compare_output_mode_field_q, clock_select_q);
				tmrwg_pkg::ADDR_COUNT: rdata_q <= counter_value_q;
				tmrwg_pkg::ADDR_CMPV: rdata_q <= compare_buffer_q;
				tmrwg_pkg::ADDR_FLAGS: rdata_q <= {6'h00, compare_match_flag_q, overflow_flag_q};
				tmrwg_pkg::ADDR_PIN: rdata_q <= {5'h00, compare_output_state_q, port_value,
					pin_direction_bit_q};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata = rdata_q;
	assign overflow_flag = overflow_flag_q;
	assign compare_match_flag = compare_match_flag_q;
endmodule : tmrwg_timer

// [tmrwg_timer_props.sv]
// checker for tmrwg_timer: readback, pin routing and flag behaviour at the ports
// assumes all registers clear on srst and the register map of tmrwg_pkg
`timescale 1ns/10ps
module tmrwg_timer_props (
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic port_value,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic overflow_flag,
	input wire logic compare_match_flag
);
	logic [7:0] ctl_q;
	logic [7:0] cmp_q;
	logic dir_q;
	logic [1:0] since_q;
	// shadows of what software wrote
	always_ff @(posedge clk) begin
		if (srst) begin
			ctl_q <= 8'h00;
			cmp_q <= 8'h00;
			dir_q <= 1'b0;
		end else if (reg_wr) begin
			ctl_q <= (reg_addr == 4'h0) ? reg_wdata : ctl_q;
			cmp_q <= (reg_addr == 4'h2) ? reg_wdata : cmp_q;
			dir_q <= (reg_addr == 4'h4) ? reg_wdata[0] : dir_q;
		end
	end
	// pin outputs lag a setting, so judge them only once settled
	always_ff @(posedge clk) begin
		if (srst || (reg_wr && (reg_addr == 4'h0 || reg_addr == 4'h4))) begin
			since_q <= 2'h0;
		end else if (since_q != 2'h3) begin
			since_q <= since_q + 2'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	cmp_readback_a: assert property (
		$past(reg_rd) && $past(reg_addr) == 4'h2 |-> reg_rdata == cmp_q)
		else $error("compare readback wrong");
	ctl_readback_a: assert property (
		$past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata == {1'b0, ctl_q[6:0]})
		else $error("control readback wrong");
	oe_follows_dir_a: assert property (since_q == 2'h3 |-> pin_oe == dir_q)
		else $error("pin enable differs from direction");
	port_pass_a: assert property (
		since_q == 2'h3 && ctl_q[5:4] == 2'h0 && dir_q && $stable(port_value)
		|-> pin_out == port_value)
		else $error("pin does not show port value");
	ovf_hold_a: assert property (
		$fell(overflow_flag) |-> $past(reg_wr && reg_addr == 4'h3 && reg_wdata[0]))
		else $error("overflow flag fell without a clear");
	cmp_hold_a: assert property (
		$fell(compare_match_flag) |-> $past(reg_wr && reg_addr == 4'h3 && reg_wdata[1]))
		else $error("compare flag fell without a clear");
	ovf_stopped_a: assert property (
		since_q == 2'h3 && ctl_q[2:0] == 3'h0 |-> !$rose(overflow_flag))
		else $error("overflow while timer stopped");
	force_no_flag_a: assert property (
		reg_wr && reg_addr == 4'h0 && reg_wdata[7] && reg_wdata[2:0] == 3'h0
		&& ctl_q[2:0] == 3'h0 |=> (!$rose(compare_match_flag)) [*3])
		else $error("force raised the compare flag");
endmodule : tmrwg_timer_props

bind tmrwg_timer tmrwg_timer_props props_i (.clk(clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.port_value(port_value), .pin_out(pin_out), .pin_oe(pin_oe),
	.overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));

// [tb_top.sv]
// testbench for tmrwg_timer: register port tasks and waveform timing checks
// assumes read data one cycle after the read strobe and registered pin outputs
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic port_value = 1'b0;
	logic [7:0] reg_rdata;
	logic pin_out, pin_oe, overflow_flag, compare_match_flag;
	int num_errors = 0;
	int checked = 0;
	int n;
	time t0, t1, t2, t3;
	logic [1:0] cm [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
	logic st [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	always #2 clk = ~clk;
	tmrwg_timer dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_value(port_value),
		.pin_out(pin_out), .pin_oe(pin_oe), .overflow_flag(overflow_flag),
		.compare_match_flag(compare_match_flag));
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] ctl(input logic f, input logic [1:0] w, input logic [1:0] c,
		input logic [2:0] s);
		return {f, w[0], c, w[1], s};
	endfunction : ctl
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask : rd
	// s high watches the overflow flag, low the pin; a run-out ends the test
	task automatic wsig(input bit s, input logic lvl, output time t);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while ((s ? overflow_flag : pin_out) !== lvl && k < 600);
		t = $time;
		if ((s ? overflow_flag : pin_out) !== lvl) begin
			num_errors++;
			complete_run();
		end
	endtask : wsig
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		// address 5 is unmapped: write ignored, reads zero
		wr(4'h5, 8'hff);
		for (int i = 0; i < 6; i++) begin
			rd(4'(i), 8'h00);
		end
		wr(4'h0, ctl(1'b1, 2'h0, 2'h3, 3'h0));
		rd(4'h4, 8'h04);
		rd(4'h3, 8'h00);
		chk(16'(pin_oe), 16'h0000);
		wr(4'h4, 8'h01);
		settle();
		chk(16'({pin_oe, pin_out}), 16'h0003);
		for (int i = 0; i < 5; i++) begin
			wr(4'h0, ctl(1'b1, 2'h0, cm[i], 3'h0));
			rd(4'h4, {5'h00, st[i], 2'h1});
			settle();
			chk(16'(pin_out), 16'(st[i] & (cm[i] != 2'h0)));
		end
		@(posedge clk);
		port_value <= 1'b1;
		settle();
		chk(16'(pin_out), 16'h0001);
		wr(4'h1, 8'hfe);
		rd(4'h1, 8'hfe);
		wr(4'h0, ctl(1'b0, 2'h0, 2'h0, 3'h1));
		wsig(1'b1, 1'b1, t1);
		wr(4'h3, 8'h01);
		wsig(1'b1, 1'b1, t2);
		chk(16'((t2 - t1) / 4), 16'h0100);
		wr(4'h0, ctl(1'b0, 2'h2, 2'h1, 3'h0));
		wr(4'h2, 8'h04);
		rd(4'h2, 8'h04);
		wr(4'h1, 8'h00);
		wr(4'h3, 8'h03);
		wr(4'h0, ctl(1'b0, 2'h2, 2'h1, 3'h1));
		wsig(1'b0, !pin_out, t1);
		wsig(1'b0, !pin_out, t2);
		chk(16'((t2 - t1) / 4), 16'h0005);
		repeat (300) @(posedge clk);
		#1;
		chk(16'({overflow_flag, compare_match_flag}), 16'h0001);
		// compare below the count is missed until the wrap
		wr(4'h0, ctl(1'b0, 2'h2, 2'h1, 3'h0));
		wr(4'h1, 8'h10);
		wr(4'h0, ctl(1'b0, 2'h2, 2'h1, 3'h1));
		t0 = $time;
		wsig(1'b1, 1'b1, t1);
		n = int'((t1 - t0) / 4);
		chk(16'(n > 236 && n < 246), 16'h0001);
		wr(4'h2, 8'h40);
		for (int k = 0; k < 2; k++) begin
			wr(4'h0, ctl(1'b0, 2'h1, 2'h2 + 2'(k), 3'h1));
			wsig(1'b0, k[0], t1);
			wsig(1'b0, !k[0], t1);
			wsig(1'b0, k[0], t2);
			wsig(1'b0, !k[0], t3);
			chk(16'((t2 - t1) / 4), 16'h0041);
			chk(16'((t3 - t1) / 4), 16'h0100);
		end
		wr(4'h3, 8'h03);
		wsig(1'b1, 1'b1, t1);
		wr(4'h2, 8'hff);
		wr(4'h0, ctl(1'b0, 2'h1, 2'h2, 3'h1));
		repeat (300) @(posedge clk);
		n = 0;
		repeat (300) begin
			@(posedge clk);
			#1;
			n += int'(pin_out !== 1'b1);
		end
		chk(16'(n), 16'h0000);
		complete_run();
	end
endmodule : tb_top
